// File: include/csl_pkg.sv
/*
 * csl_pkg: constants and carrier types for the card slot support logic.
 * Assumes a 32-bit transfer address from the static memory controller and
 * active-low strobes on both sides of the block.
 */
package csl_pkg;

    // card chip-select address windows (upper nibble of address)
    localparam logic [3:0] CSL_CS4_NIBBLE = 4'h5;
    localparam logic [3:0] CSL_CS5_NIBBLE = 4'h6;
    localparam int         CSL_NIB_HI     = 31;
    localparam int         CSL_NIB_LO     = 28;

    // mode field within the transfer address
    localparam int         CSL_MODE_HI    = 23;
    localparam int         CSL_MODE_LO    = 21;
    localparam int         CSL_REG_BIT    = 22;
    localparam int         CSL_RNW_BIT    = 25;
    localparam logic [2:0] CSL_MODE_ATTR  = 3'h0;
    localparam logic [2:0] CSL_MODE_COMM  = 3'h2;
    localparam logic [2:0] CSL_MODE_IO    = 3'h4;
    localparam logic [2:0] CSL_MODE_IDE   = 3'h6;
    localparam logic [2:0] CSL_MODE_AIDE  = 3'h7;

    // bus widths
    localparam int         CSL_DATA_W     = 32;
    localparam int         CSL_ADDR_W     = 26;
    localparam logic [1:0] CSL_BW_8       = 2'h0;
    localparam logic [1:0] CSL_BW_16      = 2'h1;

    // reset values
    localparam logic       CSL_PULLUP_RST = 1'b1;
    localparam logic       CSL_STROBE_OFF = 1'b1;

    typedef enum logic [2:0] {
        CSL_ATTR, CSL_COMM, CSL_IO, CSL_IDE, CSL_AIDE, CSL_NONE
    } csl_mode_type;

    // controller-side strobes, all active low
    typedef struct packed {
        logic       cs4_n;
        logic       cs5_n;
        logic       rd_n;
        logic       wr_n;
        logic       bs0_n;
        logic       bs1_n;
    } csl_strobe_type;

    // card-side pin group, active low except rnw
    typedef struct packed {
        logic       ce1_n;
        logic       ce2_n;
        logic       oe_n;
        logic       we_n;
        logic       ior_n;
        logic       iow_n;
        logic       cfcs0_n;
        logic       cfcs1_n;
        logic       rnw;
    } csl_card_type;

endpackage : csl_pkg

// File: rtl/csl_card_slot.sv
/*
 * csl_card_slot: card slot support logic of the external bus interface.
 * Assumes strobes and address from the static memory controller and the
 * sdram controller arrive synchronous to i_clk; every pin leaves registered,
 * so card strobes trail controller strobes by one clock.
 */
// Overview of operation
// - card logic works on chip selects four/five only when assigned
// - chip select four at 0x5xxxxxxx, five at 0x6xxxxxxx
// - address bits 23..21 pick attribute, common, io, ide, alt ide
// - address bit 22 drives register select except in true ide and alternate true ide
// - all five modes handled; 16-bit io and ide-select ignored
// - card enables follow their chip-select waveform
// - 16-bit byte-select: high enable from bs1, low from bs0
// - 8-bit common/io: high enable high, low enable low
// - true ide: high enable high, low enable low
// - alternate true ide: high enable low, low enable high
// - standby or unassigned space: both enables high
// - io/ide: strobes on io lines; mem write off; oe low in ide
// - memory modes: strobes on oe/we; io lines held high
// - mux shares 32 data, 26 address, controls by requester
// - address and output controls stable while idle
// - bus handover waits for the controller float time
// - sdram refresh never delays static accesses
// - data pull-ups on after reset, off when disable bit set
// - assigned card chip-select pin carries only card function
// - read-not-write stays valid through the whole transfer
`timescale 1ns/1ps
module csl_card_slot
    import csl_pkg::*;
#(
    parameter int DATA_W = CSL_DATA_W,
    parameter int ADDR_W = CSL_ADDR_W
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_cs_four_card_assign,
    input  wire logic                 i_cs_five_card_assign,
    input  wire logic                 i_data_pullup_disable,
    input  wire logic                 i_card_standby,
    input  wire logic [1:0]           i_bus_width_field,
    input  wire logic [31:0]          i_smc_addr,
    input  wire logic                 i_smc_rnw,
    input  wire csl_strobe_type       i_smc_strobe,
    input  wire logic                 i_smc_req,
    input  wire logic                 i_smc_float_done,
    input  wire logic [DATA_W-1:0]    i_smc_wdata,
    input  wire logic                 i_sdram_req,
    input  wire logic [ADDR_W-1:0]    i_sdram_addr,
    input  wire logic [DATA_W-1:0]    i_sdram_wdata,
    input  wire logic                 i_sdram_wr,
    output logic [ADDR_W-1:0]         o_addr,
    output logic [DATA_W-1:0]         o_data,
    output logic [DATA_W-1:0]         o_data_oe,
    output logic                      o_reg_n,
    output csl_card_type              o_card,
    output logic                      o_chip_select_four,
    output logic                      o_chip_select_five,
    output logic                      o_sdram_owner,
    output logic                      o_data_pullup_en
);

    ////////////////////////////////////////////////////////////////////////
    // address decode

    logic         hit4;
    logic         hit5;
    logic         card_hit;
    logic         card_cs_n;
    logic [2:0]   mode_bits;
    csl_mode_type mode;

    always_comb begin
        hit4 = i_cs_four_card_assign &&
               (i_smc_addr[CSL_NIB_HI:CSL_NIB_LO] == CSL_CS4_NIBBLE);
        hit5 = i_cs_five_card_assign &&
               (i_smc_addr[CSL_NIB_HI:CSL_NIB_LO] == CSL_CS5_NIBBLE);
        card_hit  = i_smc_req && (hit4 || hit5);
        card_cs_n = hit4 ? i_smc_strobe.cs4_n : i_smc_strobe.cs5_n;
        mode_bits = i_smc_addr[CSL_MODE_HI:CSL_MODE_LO];
        // undefined codes fall to no-card so no enable or command strobe fires
        case (mode_bits)
            CSL_MODE_ATTR: mode = CSL_ATTR;
            CSL_MODE_COMM: mode = CSL_COMM;
            CSL_MODE_IO:   mode = CSL_IO;
            CSL_MODE_IDE:  mode = CSL_IDE;
            CSL_MODE_AIDE: mode = CSL_AIDE;
            default:       mode = CSL_NONE;
        endcase
        if (!card_hit) begin
            mode = CSL_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // card enables, strobe steering and next pin values

    csl_card_type card_nxt;
    logic         wide;

    always_comb begin
        wide     = (i_bus_width_field == CSL_BW_16);
        card_nxt = '1; // everything deasserted by default
        card_nxt.rnw     = o_card.rnw;
        card_nxt.cfcs0_n = hit4 && card_hit ? i_smc_strobe.cs4_n : 1'b1;
        card_nxt.cfcs1_n = hit5 && card_hit ? i_smc_strobe.cs5_n : 1'b1;
        // io16 and ide-select inputs deliberately absent
        if (!i_card_standby && mode != CSL_NONE && !card_cs_n) begin
            card_nxt.rnw = i_smc_rnw;
            case (mode)
                CSL_ATTR: begin
                    // even byte only, width must be 16
                    card_nxt.ce2_n = i_smc_strobe.bs1_n;
                    card_nxt.ce1_n = i_smc_strobe.bs0_n;
                    card_nxt.oe_n  = i_smc_strobe.rd_n;
                    card_nxt.we_n  = i_smc_strobe.wr_n;
                end
                CSL_COMM, CSL_IO: begin
                    card_nxt.ce2_n = wide ? i_smc_strobe.bs1_n : 1'b1;
                    card_nxt.ce1_n = wide ? i_smc_strobe.bs0_n : 1'b0;
                    if (mode == CSL_COMM) begin
                        card_nxt.oe_n = i_smc_strobe.rd_n;
                        card_nxt.we_n = i_smc_strobe.wr_n;
                    end else begin
                        card_nxt.ior_n = i_smc_strobe.rd_n;
                        card_nxt.iow_n = i_smc_strobe.wr_n;
                    end
                end
                CSL_IDE: begin
                    card_nxt.ce2_n = 1'b1;
                    card_nxt.ce1_n = 1'b0;
                    card_nxt.oe_n  = 1'b0;
                    card_nxt.ior_n = i_smc_strobe.rd_n;
                    card_nxt.iow_n = i_smc_strobe.wr_n;
                end
                CSL_AIDE: begin
                    card_nxt.ce2_n = 1'b0;
                    card_nxt.ce1_n = 1'b1;
                    card_nxt.oe_n  = 1'b0;
                    card_nxt.ior_n = i_smc_strobe.rd_n;
                    card_nxt.iow_n = i_smc_strobe.wr_n;
                end
                default: begin
                    card_nxt.ce1_n = 1'b1;
                end
            endcase
        end
    end

    // card pins; enables copy the chip-select waveform one clock later
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_card <= '1;
        end else begin
            o_card <= card_nxt;
        end
    end

    // register-select follows address bit 22 except in true ide and alternate true ide
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_reg_n <= 1'b1;
        end else if (card_hit && mode != CSL_NONE) begin
            o_reg_n <= (mode == CSL_IDE || mode == CSL_AIDE) ? 1'b1
                       : i_smc_addr[CSL_REG_BIT];
        end
    end

    // chip-select pins carry the plain selects only when not assigned
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_chip_select_four <= CSL_STROBE_OFF;
            o_chip_select_five <= CSL_STROBE_OFF;
        end else begin
            o_chip_select_four <= i_cs_four_card_assign ? 1'b1
                                  : i_smc_strobe.cs4_n;
            o_chip_select_five <= i_cs_five_card_assign ? 1'b1
                                  : i_smc_strobe.cs5_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared address and data mux

    // static owns the bus once its float time has run out; sdram refresh
    // (req without write) drives the shared address but no data; static wins, so it never stalls static
    logic smc_owns;
    assign smc_owns = i_smc_req && i_smc_float_done;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_addr        <= '0;
            o_sdram_owner <= 1'b0;
        end else if (smc_owns) begin
            o_addr        <= i_smc_addr[ADDR_W-1:0];
            o_sdram_owner <= 1'b0;
        end else if (i_sdram_req) begin
            o_addr        <= i_sdram_addr;
            o_sdram_owner <= 1'b1;
        end
        // idle: address holds its last value, no toggling
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_data    <= '0;
            o_data_oe <= '0;
        end else if (smc_owns) begin
            o_data    <= i_smc_wdata;
            o_data_oe <= {DATA_W{!i_smc_rnw}};
        end else if (i_sdram_req && i_sdram_wr) begin
            o_data    <= i_sdram_wdata;
            o_data_oe <= '1;
        end else begin
            o_data_oe <= '0;
        end
    end

    // pull-ups on data low half, enabled out of reset
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_data_pullup_en <= CSL_PULLUP_RST;
        end else begin
            o_data_pullup_en <= !i_data_pullup_disable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    a_pullup_reset: assert property (@(posedge i_clk)
        $fell(i_sys_rst) |-> o_data_pullup_en)
        else $error("pull-ups not enabled after reset");

    a_pullup_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_data_pullup_disable ##1 !i_sys_rst |-> !o_data_pullup_en)
        else $error("pull-ups stay on though disabled");

    a_enables_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_card_standby || !card_hit)
        |=> (o_card.ce1_n && o_card.ce2_n))
        else $error("card enable active in standby or unassigned");

    a_io_lines_mem: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (card_hit && (mode == CSL_ATTR || mode == CSL_COMM))
        |=> (o_card.ior_n && o_card.iow_n))
        else $error("io strobe active in memory mode");

    a_ide_oe_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (card_hit && mode == CSL_IDE && !card_cs_n && !i_card_standby)
        |=> (!o_card.oe_n && o_card.we_n && !o_card.ce1_n))
        else $error("true ide output enable not low");

    a_alt_enables: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (card_hit && mode == CSL_AIDE && !card_cs_n && !i_card_standby)
        |=> (!o_card.ce2_n && o_card.ce1_n))
        else $error("alternate ide enables wrong");

    a_eight_bit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (card_hit && mode == CSL_COMM && !wide && !card_cs_n
         && !i_card_standby) |=> (o_card.ce2_n && !o_card.ce1_n))
        else $error("8-bit common enables wrong");

    a_cs_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (card_hit && hit4)
        |=> (o_card.cfcs0_n == $past(i_smc_strobe.cs4_n)))
        else $error("card select does not follow chip select");

    // wide memory and attribute cycles hand the byte selects straight over
    a_wide_bytes: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (card_hit && (mode == CSL_ATTR || (mode == CSL_COMM && wide))
         && !card_cs_n && !i_card_standby)
        |=> (o_card.ce1_n == $past(i_smc_strobe.bs0_n)
             && o_card.ce2_n == $past(i_smc_strobe.bs1_n)))
        else $error("byte selects not steered to card enables");

    a_reg_select: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (card_hit
         && (mode == CSL_ATTR || mode == CSL_COMM || mode == CSL_IO))
        |=> (o_reg_n == $past(i_smc_addr[CSL_REG_BIT])))
        else $error("register select does not follow address");

    a_rnw_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_card_standby || mode == CSL_NONE || card_cs_n)
        |=> $stable(o_card.rnw))
        else $error("card direction moved outside a transfer");

    a_cs_dedicated: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_cs_four_card_assign |=> o_chip_select_four)
        else $error("assigned chip select pin still driven");

    a_addr_stable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!smc_owns && !i_sdram_req) |=> $stable(o_addr))
        else $error("address moved while idle");

    c_ide_access: cover property (@(posedge i_clk)
        card_hit && mode == CSL_IDE && !card_cs_n);
    c_common_wide: cover property (@(posedge i_clk)
        card_hit && mode == CSL_COMM && wide && !card_cs_n);
    c_sdram_write: cover property (@(posedge i_clk)
        i_sdram_req && i_sdram_wr && !smc_owns);
    c_alt_ide: cover property (@(posedge i_clk)
        card_hit && mode == CSL_AIDE && !card_cs_n);
    c_standby_hit: cover property (@(posedge i_clk)
        card_hit && i_card_standby && !card_cs_n);

endmodule : csl_card_slot

// File: dv/csl_card_model.sv
/*
 * csl_card_model: removable card slot as seen behind the data buffers.
 * Assumes the card pins come straight from csl_card_slot; it only decodes
 * which kind of cycle the card would perform and reports it as a code.
 */
`timescale 1ns/1ps
module csl_card_model
    import csl_pkg::*;
(
    input  wire csl_card_type i_card,
    output logic [2:0]        o_kind
);
    ////////////////////////////////////////////////////////////////////////
    // cycle decode: 0 none, 1 mem read, 2 mem write, 3 io read, 4 io write
    // io lines win over oe, since true ide holds oe low the whole time
    always_comb begin
        if (i_card.ce1_n & i_card.ce2_n)
            o_kind = 3'h0;
        else if (!i_card.ior_n)
            o_kind = 3'h3;
        else if (!i_card.iow_n)
            o_kind = 3'h4;
        else if (!i_card.we_n)
            o_kind = 3'h2;
        else if (!i_card.oe_n)
            o_kind = 3'h1;
        else
            o_kind = 3'h5; // selected but no command yet
    end
endmodule : csl_card_model

// File: dv/testbench.sv
/*
 * testbench: directed checks of the card slot support logic.
 * Assumes registered outputs one clock behind the inputs and a synchronous
 * active-high reset; expected pin values are rebuilt from the mode tables.
 */
`timescale 1ns/1ps
module testbench;
    import csl_pkg::*;
    logic                 i_clk = 1'b0;
    logic                 i_sys_rst = 1'b1;
    logic                 i_cs_four_card_assign = 1'b1;
    logic                 i_cs_five_card_assign = 1'b1;
    logic                 i_data_pullup_disable = 1'b0;
    logic                 i_card_standby = 1'b0;
    logic [1:0]           i_bus_width_field = CSL_BW_16;
    logic [31:0]          i_smc_addr = 32'h0;
    logic                 i_smc_rnw = 1'b1;
    csl_strobe_type       i_smc_strobe = '1;
    logic                 i_smc_req = 1'b0;
    logic                 i_smc_float_done = 1'b1;
    logic [31:0]          i_smc_wdata = 32'h1234_abcd;
    logic                 i_sdram_req = 1'b0;
    logic [25:0]          i_sdram_addr = 26'h0;
    logic [31:0]          i_sdram_wdata = 32'h0;
    logic                 i_sdram_wr = 1'b0;
    logic [25:0]          o_addr;
    logic [31:0]          o_data;
    logic [31:0]          o_data_oe;
    logic                 o_reg_n;
    csl_card_type         o_card;
    logic                 o_chip_select_four;
    logic                 o_chip_select_five;
    logic                 o_sdram_owner;
    logic                 o_data_pullup_en;
    logic [2:0]           kind;
    logic [2:0]           modes [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
    int                   fails = 0;
    int                   check_count = 0;

    csl_card_slot csl_card_slot_inst (.i_clk, .i_sys_rst,
        .i_cs_four_card_assign, .i_cs_five_card_assign,
        .i_data_pullup_disable, .i_card_standby, .i_bus_width_field,
        .i_smc_addr, .i_smc_rnw, .i_smc_strobe, .i_smc_req,
        .i_smc_float_done, .i_smc_wdata, .i_sdram_req, .i_sdram_addr,
        .i_sdram_wdata, .i_sdram_wr, .o_addr, .o_data, .o_data_oe,
        .o_reg_n, .o_card, .o_chip_select_four, .o_chip_select_five,
        .o_sdram_owner, .o_data_pullup_en);
    csl_card_model csl_card_model_inst (.i_card(o_card), .o_kind(kind));

    always #25 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////
    // one controller access; outputs are sampled after the design's edge
    task automatic acc(input logic [31:0] a, input logic c4,
                       input logic c5, input logic rd, input logic [1:0] bs,
                       input logic w16);
        @(posedge i_clk);
        i_bus_width_field <= w16 ? CSL_BW_16 : CSL_BW_8;
        i_smc_addr        <= a;
        i_smc_rnw         <= rd;
        i_smc_req         <= !(c4 & c5);
        i_smc_strobe      <= '{c4, c5, !rd | (c4 & c5), rd | (c4 & c5),
                               bs[0], bs[1]};
        @(posedge i_clk);
        #1;
    endtask : acc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // {ce1, ce2, oe, we, ior, iow}; bs[0] is byte select 0
    function automatic logic [5:0] exp_card(input logic [2:0] m,
        input logic w16, input logic rd, input logic [1:0] bs);
        logic [1:0] ce;
        if (m == CSL_MODE_ATTR || (w16 && m < CSL_MODE_IDE))
            ce = {bs[0], bs[1]};
        else if (m == CSL_MODE_AIDE)
            ce = 2'h2;
        else
            ce = 2'h1;
        if (m < CSL_MODE_IO)
            return {ce, !rd, rd, 2'h3};
        return {ce, m == CSL_MODE_IO, 1'b1, !rd, rd};
    endfunction : exp_card

    function automatic logic [5:0] pins();
        return {o_card.ce1_n, o_card.ce2_n, o_card.oe_n, o_card.we_n,
                o_card.ior_n, o_card.iow_n};
    endfunction : pins

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////
    // main sequence; software keeps pins routed and widths set as needed
    initial begin
        logic [31:0] a;
        repeat (10) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        chk({o_card, o_reg_n, o_chip_select_four, o_chip_select_five},
            12'hfff);
        chk({o_sdram_owner, o_addr}, 27'h0);
        chk(o_data_oe, 32'h0);
        chk(o_data, 32'h0);
        chk(o_data_pullup_en, 1'b1);
        $display("test reset done");
        foreach (modes[m]) for (int w = 0; w < 2; w++)
            for (int r = 0; r < 2; r++) for (int b = 1; b < 3; b++) begin
                a = 32'h5000_0abc | (32'(modes[m]) << 21);
                acc(a, 1'b0, 1'b1, r[0], b[1:0], w[0]);
                chk(pins(), exp_card(modes[m], w[0], r[0], b[1:0]));
                chk(o_reg_n, (modes[m][2:1] == 2'h3) | modes[m][1]);
                chk(kind, r ? (modes[m] < 4 ? 1 : 3)
                            : (modes[m] < 4 ? 2 : 4));
                chk({o_card.cfcs0_n, o_card.rnw, o_chip_select_four},
                    {1'b0, r[0], 1'b1});
            end
        $display("test mode table done");
        acc(32'h6040_0010, 1'b1, 1'b0, 1'b1, 2'h2, 1'b1);
        chk({pins(), o_card.cfcs1_n}, {6'h17, 1'b0});
        chk(o_addr[24:0], 25'h040_0010);
        acc(32'h6040_0010, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1);
        chk({pins(), o_addr[24:0], o_card.rnw},
            {6'h3f, 25'h040_0010, 1'b1});
        @(posedge i_clk);
        i_sdram_req <= 1'b1;
        acc(32'h5040_0000, 1'b0, 1'b1, 1'b0, 2'h0, 1'b1);
        chk(pins(), 6'h0b);
        chk({o_sdram_owner, o_addr}, {1'b0, 26'h040_0000});
        chk(o_data_oe, 32'hffff_ffff);
        chk(o_data, 32'h1234_abcd);
        // sdram alone on the bus takes the shared address and data lines
        @(posedge i_clk);
        i_sdram_wr    <= 1'b1;
        i_sdram_addr  <= 26'h012_3456;
        i_sdram_wdata <= 32'h5a5a_0f0f;
        acc(32'h5040_0000, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1);
        chk({o_sdram_owner, o_addr}, {1'b1, 26'h012_3456});
        chk(o_data, 32'h5a5a_0f0f);
        // static request before its float time leaves shared lines alone
        @(posedge i_clk);
        i_sdram_req      <= 1'b0;
        i_sdram_wr       <= 1'b0;
        i_smc_float_done <= 1'b0;
        acc(32'h5040_0000, 1'b0, 1'b1, 1'b0, 2'h0, 1'b1);
        chk({o_sdram_owner, o_addr}, {1'b1, 26'h012_3456});
        chk(o_data_oe, 32'h0);
        @(posedge i_clk);
        i_smc_float_done <= 1'b1;
        $display("test second space done");
        acc(32'h5020_0000, 1'b0, 1'b1, 1'b1, 2'h2, 1'b1);
        chk(pins(), 6'h3f);
        acc(32'h4040_0000, 1'b0, 1'b1, 1'b1, 2'h2, 1'b1);
        chk({pins(), o_card.cfcs0_n}, 7'h7f);
        @(posedge i_clk);
        i_card_standby <= 1'b1;
        acc(32'h5040_0000, 1'b0, 1'b1, 1'b1, 2'h2, 1'b1);
        chk(pins(), 6'h3f);
        @(posedge i_clk);
        i_card_standby <= 1'b0;
        i_cs_four_card_assign <= 1'b0;
        acc(32'h5040_0000, 1'b0, 1'b1, 1'b1, 2'h2, 1'b1);
        chk({pins(), o_chip_select_four, o_chip_select_five}, 8'hfd);
        @(posedge i_clk);
        i_data_pullup_disable <= 1'b1;
        acc(32'h5040_0000, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1);
        chk(o_data_pullup_en, 1'b0);
        $display("test refusals done");
        report_and_stop();
    end
endmodule : testbench
